// [src/iop_pkg.sv]
/*
  constants, register map and state codes for the i/o port control block.
  assumes one 8-pin port, an 8-bit register port on sys_clk, and an
  nvm reader that answers a read request on the same clock.
*/
// Behaviour
// - pins sit in high-z analog during reset
// - per-port drive choice of pull-up or pull-down
// - reset config copied from nvm at release
// - pin outputs held in low-power modes
// - pin interrupt detection runs in low power
// - one threshold shared by the special pin pair
// - pair threshold may come from analog global
// - hysteresis enable for special pin input buffer
// - every pin reachable by boundary scan
// - per-pin rise, fall, both or none detection
// - event sets status bit and raises request
package iop_pkg;

  localparam int PINS = 8;
  localparam int AW = 4;
  localparam int DW = 8;

  // register byte addresses
  localparam logic [3:0] ADDR_OUT = 4'h0;
  localparam logic [3:0] ADDR_DM_LO = 4'h1;
  localparam logic [3:0] ADDR_DM_HI = 4'h2;
  localparam logic [3:0] ADDR_IN = 4'h3;
  localparam logic [3:0] ADDR_IM_LO = 4'h4;
  localparam logic [3:0] ADDR_IM_HI = 4'h5;
  localparam logic [3:0] ADDR_STAT = 4'h6;
  localparam logic [3:0] ADDR_MASK = 4'h7;
  localparam logic [3:0] ADDR_PAIR_REF = 4'h8;
  localparam logic [3:0] ADDR_RCFG = 4'h9;

  // pair reference control field positions
  localparam int PAIR_THR_LSB = 0;
  localparam int PAIR_HYST_BIT = 2;
  localparam int PAIR_AGL_BIT = 3;

  // pin drive modes, two bits per pin
  localparam logic [1:0] DM_HIZ_ANALOG = 2'h0;
  localparam logic [1:0] DM_PULL_UP = 2'h1;
  localparam logic [1:0] DM_PULL_DOWN = 2'h2;
  localparam logic [1:0] DM_STRONG = 2'h3;

  // pin interrupt modes, two bits per pin
  localparam logic [1:0] IM_NONE = 2'h0;
  localparam logic [1:0] IM_RISE = 2'h1;
  localparam logic [1:0] IM_FALL = 2'h2;
  localparam logic [1:0] IM_BOTH = 2'h3;

  // values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_DM = 16'h0000;
  localparam logic [1:0] RST_CFG = 2'h0;
  localparam logic [3:0] RST_PAIR_REF = 4'h0;

  // reset configuration loader states
  typedef enum logic [2:0] {
    LD_REQ = 3'b001,
    LD_WAIT = 3'b010,
    LD_DONE = 3'b100
  } iop_ld_e;

endpackage

// [src/iop_edge_det.sv]
/*
  per-pin edge detector for the port interrupt unit.
  assumes its level input is already synchronised to sys_clk.
*/
module iop_edge_det (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // level and mode
  input wire logic level,
  input wire logic [1:0] mode,
  // detected event
  output logic event_p
);

  logic prev_r;
  logic rise;
  logic fall;

  // previous level, kept running in every power mode
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= level;
    end
  end

  assign rise = level & ~prev_r;
  assign fall = ~level & prev_r;

  // mode select of the event
  always_comb begin
    unique case (mode)
      iop_pkg::IM_NONE: event_p = 1'b0;
      iop_pkg::IM_RISE: event_p = rise;
      iop_pkg::IM_FALL: event_p = fall;
      iop_pkg::IM_BOTH: event_p = rise | fall;
    endcase
  end

endmodule // iop_edge_det

// [src/iop_port.sv]
/*
  i/o port control: drive modes, reset configuration load, pin
  interrupts, special pin pair threshold and boundary scan reach.
  assumes the tap logic and nvm reader run on sys_clk; pin inputs
  arrive asynchronously and are synchronised here.
*/
module iop_port (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,

  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,

  // nonvolatile reset configuration
  output logic nvm_rd_req,
  input wire logic nvm_rd_valid,
  input wire logic [1:0] nvm_rd_data,

  // power state
  input wire logic lp_mode,

  // pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pu_en,
  output logic [7:0] pin_pd_en,
  output logic [7:0] pin_analog,

  // boundary scan
  input wire logic bsr_extest,
  input wire logic [7:0] bsr_out,
  input wire logic [7:0] bsr_oe,
  output logic [7:0] bsr_capture,

  // special pin pair reference
  output logic [1:0] pair_thr_sel,
  output logic pair_ref_agl,
  output logic pair_hyst_en,

  // interrupt and wake
  output logic irq,
  output logic wake_req
);

  // register state
  logic [7:0] out_r;
  logic [15:0] dm_r;
  logic [15:0] im_r;
  logic [7:0] stat_r;
  logic [7:0] mask_r;
  logic [3:0] pair_ref_r;
  logic [1:0] rcfg_r;
  logic [7:0] rdata_r;
  logic irq_r;
  logic wake_r;
  logic nvm_req_r;
  iop_pkg::iop_ld_e ld_r;
  iop_pkg::iop_ld_e ld_nxt;

  // pin path state
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic [7:0] cap_r;
  logic [7:0] pout_r;
  logic [7:0] poe_r;
  logic [7:0] ppu_r;
  logic [7:0] ppd_r;
  logic [7:0] pana_r;

  // decoded strobes
  logic wr_ok;
  logic loaded;
  logic ld_fire;
  logic [7:0] evt;
  logic [7:0] stat_nxt;
  logic [15:0] dm_fill;

  // writes that change pin state are held off in low power
  assign wr_ok = reg_wr & ~lp_mode;
  assign loaded = (ld_r == iop_pkg::LD_DONE);
  assign ld_fire = (ld_r == iop_pkg::LD_WAIT) & nvm_rd_valid;

  // every pin of the port takes the loaded config
  assign dm_fill = {iop_pkg::PINS{nvm_rd_data}};

  // two-flop synchroniser for the pin levels
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= iop_pkg::RST_BYTE;
      sync2_r <= iop_pkg::RST_BYTE;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end

  // reset configuration loader, next state
  always_comb begin
    ld_nxt = ld_r;
    unique case (ld_r)
      iop_pkg::LD_REQ: ld_nxt = iop_pkg::LD_WAIT;
      iop_pkg::LD_WAIT: begin
        if (nvm_rd_valid) begin
          ld_nxt = iop_pkg::LD_DONE;
        end
      end
      iop_pkg::LD_DONE: ld_nxt = iop_pkg::LD_DONE;
      default: ld_nxt = iop_pkg::LD_REQ;
    endcase
  end

  // loader state, starts by itself at reset release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ld_r <= iop_pkg::LD_REQ;
    end else begin
      ld_r <= ld_nxt;
    end
  end

  // read request stands until the nvm answers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      nvm_req_r <= 1'b0;
    end else begin
      nvm_req_r <= (ld_nxt == iop_pkg::LD_WAIT);
    end
  end

  // loaded reset configuration copy
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rcfg_r <= iop_pkg::RST_CFG;
    end else if (ld_fire) begin
      rcfg_r <= nvm_rd_data;
    end
  end

  // output data register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_r <= iop_pkg::RST_BYTE;
    end else if (wr_ok && reg_addr == iop_pkg::ADDR_OUT) begin
      out_r <= reg_wdata;
    end
  end

  // drive modes: load fills, a software write wins over it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dm_r <= iop_pkg::RST_DM;
    end else begin
      if (ld_fire) begin
        dm_r <= dm_fill;
      end
      if (wr_ok && reg_addr == iop_pkg::ADDR_DM_LO) begin
        dm_r[7:0] <= reg_wdata;
      end
      if (wr_ok && reg_addr == iop_pkg::ADDR_DM_HI) begin
        dm_r[15:8] <= reg_wdata;
      end
    end
  end

  // interrupt mode registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      im_r <= iop_pkg::RST_DM;
    end else begin
      if (reg_wr && reg_addr == iop_pkg::ADDR_IM_LO) begin
        im_r[7:0] <= reg_wdata;
      end
      if (reg_wr && reg_addr == iop_pkg::ADDR_IM_HI) begin
        im_r[15:8] <= reg_wdata;
      end
    end
  end

  // interrupt mask register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= iop_pkg::RST_BYTE;
    end else if (reg_wr && reg_addr == iop_pkg::ADDR_MASK) begin
      mask_r <= reg_wdata;
    end
  end

  // shared reference control of the special pin pair
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pair_ref_r <= iop_pkg::RST_PAIR_REF;
    end else if (reg_wr && reg_addr == iop_pkg::ADDR_PAIR_REF) begin
      pair_ref_r <= reg_wdata[3:0];
    end
  end

  // per-pin edge detection
  genvar gi;
  generate
    for (gi = 0; gi < iop_pkg::PINS; gi++) begin : g_pin
      iop_edge_det u_edge (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .level(sync2_r[gi]),
        .mode(im_r[2*gi+1 -: 2]),
        .event_p(evt[gi])
      );

      // registered pin drive decode
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          pout_r[gi] <= 1'b0;
          poe_r[gi] <= 1'b0;
          ppu_r[gi] <= 1'b0;
          ppd_r[gi] <= 1'b0;
          pana_r[gi] <= 1'b1;
        end else if (bsr_extest) begin
          pout_r[gi] <= bsr_out[gi];
          poe_r[gi] <= bsr_oe[gi];
          ppu_r[gi] <= 1'b0;
          ppd_r[gi] <= 1'b0;
          pana_r[gi] <= 1'b0;
        end else if (!loaded) begin
          pout_r[gi] <= 1'b0;
          poe_r[gi] <= 1'b0;
          ppu_r[gi] <= 1'b0;
          ppd_r[gi] <= 1'b0;
          pana_r[gi] <= 1'b1;
        end else begin
          pout_r[gi] <= out_r[gi];
          pana_r[gi] <= 1'b0;
          unique case (dm_r[2*gi+1 -: 2])
            iop_pkg::DM_HIZ_ANALOG: begin
              poe_r[gi] <= 1'b0;
              ppu_r[gi] <= 1'b0;
              ppd_r[gi] <= 1'b0;
              pana_r[gi] <= 1'b1;
            end
            iop_pkg::DM_PULL_UP: begin
              poe_r[gi] <= ~out_r[gi];
              ppu_r[gi] <= out_r[gi];
              ppd_r[gi] <= 1'b0;
            end
            iop_pkg::DM_PULL_DOWN: begin
              poe_r[gi] <= out_r[gi];
              ppu_r[gi] <= 1'b0;
              ppd_r[gi] <= ~out_r[gi];
            end
            iop_pkg::DM_STRONG: begin
              poe_r[gi] <= 1'b1;
              ppu_r[gi] <= 1'b0;
              ppd_r[gi] <= 1'b0;
            end
          endcase
        end
      end
    end
  endgenerate

  // sticky status: a new event wins over a write-one clear
  always_comb begin
    stat_nxt = stat_r;
    if (reg_wr && reg_addr == iop_pkg::ADDR_STAT) begin
      stat_nxt = stat_r & ~reg_wdata;
    end
    stat_nxt = stat_nxt | evt;
  end

  // status register, clocked in every power mode
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_r <= iop_pkg::RST_BYTE;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // request to the interrupt controller and wake line
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      irq_r <= |(stat_nxt & mask_r);
      wake_r <= lp_mode & |(stat_nxt & mask_r);
    end
  end

  // boundary scan capture of the pin levels
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_r <= iop_pkg::RST_BYTE;
    end else begin
      cap_r <= sync2_r;
    end
  end

  // read data, valid the cycle after the strobe only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= iop_pkg::RST_BYTE;
    end else if (reg_rd) begin
      unique case (reg_addr)
        iop_pkg::ADDR_OUT: rdata_r <= out_r;
        iop_pkg::ADDR_DM_LO: rdata_r <= dm_r[7:0];
        iop_pkg::ADDR_DM_HI: rdata_r <= dm_r[15:8];
        iop_pkg::ADDR_IN: rdata_r <= sync2_r;
        iop_pkg::ADDR_IM_LO: rdata_r <= im_r[7:0];
        iop_pkg::ADDR_IM_HI: rdata_r <= im_r[15:8];
        iop_pkg::ADDR_STAT: rdata_r <= stat_r;
        iop_pkg::ADDR_MASK: rdata_r <= mask_r;
        iop_pkg::ADDR_PAIR_REF: rdata_r <= {4'h0, pair_ref_r};
        iop_pkg::ADDR_RCFG: rdata_r <= {5'h00, loaded, rcfg_r};
        default: rdata_r <= iop_pkg::RST_BYTE;
      endcase
    end else begin
      rdata_r <= iop_pkg::RST_BYTE;
    end
  end

  // outputs straight from flops
  assign reg_rdata = rdata_r;
  assign nvm_rd_req = nvm_req_r;
  assign pin_out = pout_r;
  assign pin_oe = poe_r;
  assign pin_pu_en = ppu_r;
  assign pin_pd_en = ppd_r;
  assign pin_analog = pana_r;
  assign bsr_capture = cap_r;

  // one threshold for both pins of the pair
  assign pair_thr_sel = pair_ref_r[iop_pkg::PAIR_THR_LSB +: 2];
  assign pair_ref_agl = pair_ref_r[iop_pkg::PAIR_AGL_BIT];
  assign pair_hyst_en = pair_ref_r[iop_pkg::PAIR_HYST_BIT];
  assign irq = irq_r;
  assign wake_req = wake_r;

endmodule // iop_port

// [testbench/iop_port_assertions.sv]
/*
  concurrent checks on the i/o port control block.
  assumes bind to iop_port; sees only its ports, one clock domain.
*/
module iop_port_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // watched ports
  input wire logic reg_wr,
  input wire logic nvm_rd_req,
  input wire logic nvm_rd_valid,
  input wire logic [1:0] nvm_rd_data,
  input wire logic lp_mode,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_analog,
  input wire logic bsr_extest,
  input wire logic [7:0] bsr_out,
  input wire logic [7:0] bsr_oe,
  input wire logic [7:0] bsr_capture,
  input wire logic [1:0] pair_thr_sel,
  input wire logic pair_ref_agl,
  input wire logic pair_hyst_en,
  input wire logic irq,
  input wire logic wake_req
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  logic [1:0] up_cnt_r;
  // edges since release, saturating at three
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      up_cnt_r <= 2'h0;
    end else if (up_cnt_r != 2'h3) begin
      up_cnt_r <= up_cnt_r + 2'h1;
    end
  end
  // non-analog config answered, no competing write
  sequence s_load;
    nvm_rd_req && nvm_rd_valid && nvm_rd_data != 2'h0 && !reg_wr && !bsr_extest;
  endsequence
  // scan idle now and two edges back, pins lag the scan by one edge
  sequence s_scan_idle;
    !bsr_extest && !$past(bsr_extest) && !$past(bsr_extest, 2);
  endsequence
  a_hold_hiz: assert property (
    nvm_rd_req ##0 s_scan_idle |-> pin_analog == 8'hFF && pin_oe == 8'h00)
    else $error("pins left analog before load");
  a_load_drop: assert property (nvm_rd_req && nvm_rd_valid |=> !nvm_rd_req)
    else $error("load request stayed up");
  a_loaded_drive: assert property (s_load |-> ##2 pin_analog == 8'h00)
    else $error("loaded drive not applied");
  a_lp_retain: assert property (
    $past(lp_mode) && $past(lp_mode, 2) ##0 s_scan_idle |-> $stable(pin_out) && $stable(pin_oe))
    else $error("pin state moved in low power");
  a_wake_follow: assert property (wake_req |-> irq && $past(lp_mode))
    else $error("wake without pending irq");
  a_scan_drive: assert property (
    bsr_extest |=> pin_out == $past(bsr_out) && pin_oe == $past(bsr_oe) && pin_analog == 8'h00)
    else $error("scan drive not applied");
  a_scan_capture: assert property (
    up_cnt_r == 2'h3 |-> bsr_capture == $past(pin_in, 3))
    else $error("capture lag wrong");
  a_ref_steady: assert property (
    !reg_wr |=> $stable({pair_ref_agl, pair_hyst_en, pair_thr_sel}))
    else $error("pair reference moved");
endmodule // iop_port_checker

bind iop_port iop_port_checker u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .nvm_rd_req(nvm_rd_req),
  .nvm_rd_valid(nvm_rd_valid), .nvm_rd_data(nvm_rd_data), .lp_mode(lp_mode),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_analog(pin_analog),
  .bsr_extest(bsr_extest), .bsr_out(bsr_out), .bsr_oe(bsr_oe), .bsr_capture(bsr_capture),
  .pair_thr_sel(pair_thr_sel), .pair_ref_agl(pair_ref_agl), .pair_hyst_en(pair_hyst_en),
  .irq(irq), .wake_req(wake_req)
);

// [testbench/iop_far_model.sv]
/*
  far side model: nonvolatile config store answering the loader.
  assumes the loader request is a level on sys_clk.
*/
module iop_far_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // config store link
  input wire logic nvm_rd_req,
  output logic nvm_rd_valid,
  output logic [1:0] nvm_rd_data,
  // stored word and answer delay
  input wire logic [1:0] cfg,
  input wire logic [3:0] lat
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] wait_r;
  logic done_r;
  // one answer per reset, done_r clears only at reset; data churns when not valid
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 4'h0;
      done_r <= 1'b0;
      nvm_rd_valid <= 1'b0;
      nvm_rd_data <= 2'h0;
    end else if (nvm_rd_req && !done_r && wait_r == lat) begin
      nvm_rd_valid <= 1'b1;
      nvm_rd_data <= cfg;
      done_r <= 1'b1;
    end else begin
      nvm_rd_valid <= 1'b0;
      nvm_rd_data <= ~nvm_rd_data;
      if (nvm_rd_req && !done_r) begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule // iop_far_model

// [testbench/test_iop_port.sv]
/*
  self-checking bench for the i/o port control block.
  assumes the far side model answers the config load.
*/
module test_iop_port;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, rst_n, reg_wr, reg_rd, nvm_rd_req, nvm_rd_valid, lp_mode, bsr_extest;
  logic pair_ref_agl, pair_hyst_en, irq, wake_req;
  logic [1:0] nvm_rd_data, pair_thr_sel, cfg;
  logic [3:0] reg_addr, lat;
  logic [7:0] reg_wdata, reg_rdata, pin_in, pin_out, pin_oe, pin_pu_en, pin_pd_en;
  logic [7:0] pin_analog, bsr_out, bsr_oe, bsr_capture;
  int failures, cmp_count;

  iop_port DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .nvm_rd_req(nvm_rd_req), .nvm_rd_valid(nvm_rd_valid), .nvm_rd_data(nvm_rd_data),
    .lp_mode(lp_mode), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pu_en(pin_pu_en), .pin_pd_en(pin_pd_en), .pin_analog(pin_analog),
    .bsr_extest(bsr_extest), .bsr_out(bsr_out), .bsr_oe(bsr_oe),
    .bsr_capture(bsr_capture), .pair_thr_sel(pair_thr_sel), .pair_ref_agl(pair_ref_agl),
    .pair_hyst_en(pair_hyst_en), .irq(irq), .wake_req(wake_req));
  iop_far_model u_far (.sys_clk(sys_clk), .rst_n(rst_n), .nvm_rd_req(nvm_rd_req),
    .nvm_rd_valid(nvm_rd_valid), .nvm_rd_data(nvm_rd_data), .cfg(cfg), .lat(lat));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic pin0(input logic v);
    @(posedge sys_clk);
    pin_in[0] <= v;
    tick(4);
  endtask
  task automatic t_reset_load(input logic [3:0] l, input logic [1:0] c, input logic [7:0] oe,
                              input logic [7:0] pd);
    rst_n <= 1'b0;
    lat <= l;
    cfg <= c;
    tick(1);
    chk(pin_analog, 8'hFF);
    chk(pin_oe, 8'h00);
    chk(pin_pu_en, 8'h00);
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    tick(2);
    chk(pin_analog, 8'hFF);
    tick(int'(l) + 3);
    chk(pin_analog, 8'h00);
    chk(pin_oe, oe);
    chk(pin_pd_en, pd);
    chk(pin_pu_en, 8'h00);
    rd(iop_pkg::ADDR_RCFG, {5'h00, 1'b1, c});
  endtask
  task automatic t_sw_drive();
    wr(iop_pkg::ADDR_DM_LO, 8'hAA);
    wr(iop_pkg::ADDR_OUT, 8'h05);
    tick(2);
    chk(pin_oe, 8'hF5);
    chk(pin_pd_en, 8'h0A);
    // upper pins: strong, analog and two pull-ups pulled high
    wr(iop_pkg::ADDR_DM_HI, 8'h53);
    wr(iop_pkg::ADDR_OUT, 8'hF5);
    tick(2);
    chk(pin_out, 8'hF5);
    chk(pin_oe, 8'h15);
    chk(pin_pu_en, 8'hC0);
    chk(pin_analog, 8'h20);
    chk(pin_pd_en, 8'h0A);
    wr(iop_pkg::ADDR_DM_HI, 8'h55);
    wr(iop_pkg::ADDR_OUT, 8'h05);
  endtask
  task automatic t_irq();
    wr(iop_pkg::ADDR_MASK, 8'h01);
    for (int m = 0; m < 4; m++) begin
      wr(iop_pkg::ADDR_IM_LO, m[7:0]);
      wr(iop_pkg::ADDR_STAT, 8'hFF);
      pin0(1'b1);
      chk({7'h00, irq}, {7'h00, (m == 1 || m == 3)});
      wr(iop_pkg::ADDR_STAT, 8'hFF);
      pin0(1'b0);
      chk({7'h00, irq}, {7'h00, (m >= 2)});
    end
    wr(iop_pkg::ADDR_MASK, 8'h00);
    wr(iop_pkg::ADDR_STAT, 8'hFF);
    pin0(1'b1);
    chk({7'h00, irq}, 8'h00);
    rd(iop_pkg::ADDR_STAT, 8'h01);
    rd(4'hF, 8'h00);
    wr(iop_pkg::ADDR_MASK, 8'h01);
    tick(2);
    chk({7'h00, irq}, 8'h01);
    wr(iop_pkg::ADDR_STAT, 8'hFF);
  endtask
  task automatic t_lowpower();
    @(posedge sys_clk);
    lp_mode <= 1'b1;
    wr(iop_pkg::ADDR_OUT, 8'hFF);
    wr(iop_pkg::ADDR_DM_LO, 8'h00);
    tick(2);
    chk(pin_out, 8'h05);
    chk(pin_oe, 8'hF5);
    pin0(1'b0);
    tick(1);
    chk({7'h00, wake_req}, 8'h01);
    @(posedge sys_clk);
    lp_mode <= 1'b0;
    wr(iop_pkg::ADDR_STAT, 8'hFF);
    tick(2);
    chk({6'h00, irq, wake_req}, 8'h00);
  endtask
  task automatic t_pair_ref();
    wr(iop_pkg::ADDR_PAIR_REF, 8'h0E);
    tick(1);
    chk({4'h0, pair_ref_agl, pair_hyst_en, pair_thr_sel}, 8'h0E);
    rd(iop_pkg::ADDR_PAIR_REF, 8'h0E);
    wr(iop_pkg::ADDR_PAIR_REF, 8'h03);
    tick(1);
    chk({4'h0, pair_ref_agl, pair_hyst_en, pair_thr_sel}, 8'h03);
  endtask
  task automatic t_extest();
    @(posedge sys_clk);
    bsr_extest <= 1'b1;
    bsr_out <= 8'hA5;
    bsr_oe <= 8'h3C;
    pin_in <= 8'h96;
    tick(4);
    chk(pin_out, 8'hA5);
    chk(pin_oe, 8'h3C);
    chk(bsr_capture, 8'h96);
    @(posedge sys_clk);
    bsr_extest <= 1'b0;
    pin_in <= 8'h00;
    tick(2);
    chk(pin_out, 8'h05);
  endtask
  task automatic report_and_stop();
    if (failures == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // free-running system clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // main sequence, prompt load first, slow load after mid-run reset
  initial begin
    {rst_n, reg_wr, reg_rd, lp_mode, bsr_extest} = 5'h00;
    {reg_addr, lat, cfg} = 10'h000;
    {reg_wdata, pin_in, bsr_out, bsr_oe} = 32'h0;
    failures = 0;
    cmp_count = 0;
    t_reset_load(4'h0, iop_pkg::DM_PULL_UP, 8'hFF, 8'h00);
    t_sw_drive();
    t_irq();
    t_lowpower();
    t_pair_ref();
    t_extest();
    t_reset_load(4'h9, iop_pkg::DM_PULL_DOWN, 8'h00, 8'hFF);
    report_and_stop();
  end
  // hang guard, far beyond the expected run
  initial begin
    #20000;
    failures++;
    report_and_stop();
  end
endmodule // test_iop_port
